// *** iru_pkg.sv ***
package iru_pkg;
	// Register offsets on the AHB-Lite slave (byte addresses).
	localparam logic [7:0] IRU_OFF_CMD    = 8'h00;
	localparam logic [7:0] IRU_OFF_BASE   = 8'h04;
	localparam logic [7:0] IRU_OFF_OPER   = 8'h08;
	localparam logic [7:0] IRU_OFF_X      = 8'h0c;
	localparam logic [7:0] IRU_OFF_Y      = 8'h10;
	localparam logic [7:0] IRU_OFF_FLAGS  = 8'h14;
	localparam logic [7:0] IRU_OFF_EA     = 8'h18;
	localparam logic [7:0] IRU_OFF_STATUS = 8'h1c;
	// Field positions of the command register.
	localparam int IRU_CMD_OP_LSB   = 0;
	localparam int IRU_CMD_MODE_LSB = 4;
	localparam int IRU_CMD_REG_BIT  = 8;
	// Field positions of the flags register.
	localparam int IRU_FLAG_C = 0;
	localparam int IRU_FLAG_Z = 1;
	localparam int IRU_FLAG_V = 6;
	localparam int IRU_FLAG_N = 7;
	// Reset values.
	localparam logic [7:0]  IRU_RST_INDEX = 8'h00;
	localparam logic [7:0]  IRU_RST_FLAGS = 8'h00;
	localparam logic [15:0] IRU_RST_BASE  = 16'h0000;
	localparam int IRU_SIGN_BIT = 7;

	// Operations on an index register.
	typedef enum logic [3:0] {
		IRU_OP_NONE = 4'h0,
		IRU_OP_LOAD = 4'h1,
		IRU_OP_INC  = 4'h2,
		IRU_OP_DEC  = 4'h3,
		IRU_OP_EA   = 4'h4
	} iru_op_t;

	// Operand sources of the load and address modes.
	typedef enum logic [2:0] {
		IRU_MODE_IMM   = 3'h0,
		IRU_MODE_ABS   = 3'h1,
		IRU_MODE_ZP    = 3'h2,
		IRU_MODE_ABSIX = 3'h3,
		IRU_MODE_ZPIX  = 3'h4,
		IRU_MODE_INDIR = 3'h5
	} iru_mode_t;

	// Memory request toward the system bus.
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} iru_mem_req_t;

	// Memory answer from the system bus.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} iru_mem_rsp_t;
endpackage

// *** iru_adder.sv ***
`timescale 1ns/1ns
`default_nettype none
// Effective address adder: the index is added to a base, with a zero-page wrap option.
module iru_adder
	import iru_pkg::*;
#(
	parameter int AW = 16,
	parameter int IW = 8
) (
	// Clock and reset.
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	// Operands.
	input  wire logic [AW-1:0] base_i,
	input  wire logic [IW-1:0] index_i,
	input  wire logic          zero_page_i,
	// Result.
	output logic      [AW-1:0] ea_o
);
	logic [AW-1:0] sum;

	// Zero-page sums stay in page zero, so the carry out of the low byte is dropped.
	always_comb begin
		sum = base_i + AW'(index_i); // [RULE_06]
		if (zero_page_i) begin
			sum = {{(AW-IW){1'b0}}, sum[IW-1:0]};
		end
	end

	// The result is registered so the address output is a flip-flop.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ea_o <= '0;
		end else begin
			ea_o <= sum;
		end
	end
endmodule
`default_nettype wire

// *** iru_top.sv ***
// Functional notes
// [RULE_01] Load X changes only X, keeps C, V
// [RULE_02] Load X sets Z when byte zero
// [RULE_03] Load X copies bit 7 into N
// [RULE_04] Load X: immediate, abs, zp, abs+Y, zp+Y
// [RULE_05] Index registers are eight bits wide
// [RULE_06] Effective address is base plus index
// [RULE_07] Both indexes increment and decrement by one
// [RULE_08] Decrement from zero wraps to all ones
// [RULE_09] Decrement reaching zero sets the Z flag
// [RULE_10] Decrement X keeps C, V; sets N, Z
// [RULE_11] Increment X wraps all ones to zero
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module iru_top
	import iru_pkg::*;
#(
	parameter int IW = 8
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	// AHB-Lite slave.
	input  wire logic         hsel_i,
	input  wire logic [31:0]  haddr_i,
	input  wire logic [1:0]   htrans_i,
	input  wire logic         hwrite_i,
	input  wire logic [2:0]   hsize_i,
	input  wire logic [31:0]  hwdata_i,
	input  wire logic         hready_i,
	output logic      [31:0]  hrdata_o,
	output logic              hreadyout_o,
	output logic              hresp_o,
	// System memory bus.
	output iru_mem_req_t      mem_req_o,
	input  wire iru_mem_rsp_t mem_rsp_i
);
	typedef enum logic [1:0] {
		IRU_ST_IDLE  = 2'b00,
		IRU_ST_ADDR  = 2'b01,
		IRU_ST_FETCH = 2'b10,
		IRU_ST_DONE  = 2'b11
	} iru_state_t;

	logic          rst_s1;
	logic          rst_n;
	logic [IW-1:0] x_index;
	logic [IW-1:0] y_index;
	logic [7:0]    flags;
	logic [15:0]   base;
	logic [IW-1:0] oper;
	logic [15:0]   ea;
	logic          err_mode;
	iru_state_t    state;
	iru_op_t       cur_op;
	iru_mode_t     cur_mode;
	logic          cur_sel_y;
	logic          dp_write;
	logic [7:0]    dp_addr;
	logic          start;
	logic          busy;
	logic [IW-1:0] adder_index;
	logic          zp_mode;
	logic          wr_index;
	logic [IW-1:0] next_index;
	logic          wr_base;
	logic          wr_oper;
	logic          wr_flags;
	logic          next_zero;
	logic          next_sign;
	logic [31:0]   next_rdata;

	// Reset is released through two flip-flops so all logic leaves reset together.
	// Assertion stays asynchronous; only the release waits for the clock.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// Decides whether a mode needs a memory fetch before the operand is known.
	function automatic logic iru_needs_fetch(input iru_mode_t m);
		iru_needs_fetch = (m != IRU_MODE_IMM);
	endfunction

	// Decides whether a mode adds an index to the base.
	function automatic logic iru_indexed(input iru_mode_t m);
		iru_indexed = (m == IRU_MODE_ABSIX) || (m == IRU_MODE_ZPIX) || (m == IRU_MODE_INDIR);
	endfunction

	// Decides whether a load may take its operand from this source.
	function automatic logic iru_load_src_ok(input logic [2:0] m);
		iru_load_src_ok = (m <= 3'(IRU_MODE_ZPIX));
	endfunction

	// AHB address phase capture; a write runs in the following data phase.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
		end else if (hready_i) begin
			dp_write <= hsel_i && htrans_i[1] && hwrite_i;
			dp_addr  <= haddr_i[7:0];
		end
	end

	// The slave never waits and always answers OKAY.
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign start       = dp_write && (dp_addr == IRU_OFF_CMD) && !busy;
	assign busy        = (state != IRU_ST_IDLE);

	// Register write strobes; writes are refused while a command runs, so software
	// cannot move the base or the operand under a fetch in flight.
	assign wr_base  = dp_write && !busy && (dp_addr == IRU_OFF_BASE);
	assign wr_oper  = dp_write && !busy && (dp_addr == IRU_OFF_OPER);
	assign wr_flags = dp_write && !busy && (dp_addr == IRU_OFF_FLAGS);

	// Read data multiplexer; unmapped offsets read zero.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (haddr_i[7:0] == IRU_OFF_BASE) begin
			next_rdata = {16'h0000, base};
		end else if (haddr_i[7:0] == IRU_OFF_OPER) begin
			next_rdata = {24'h000000, oper};
		end else if (haddr_i[7:0] == IRU_OFF_X) begin
			next_rdata = {24'h000000, x_index};
		end else if (haddr_i[7:0] == IRU_OFF_Y) begin
			next_rdata = {24'h000000, y_index};
		end else if (haddr_i[7:0] == IRU_OFF_FLAGS) begin
			next_rdata = {24'h000000, flags};
		end else if (haddr_i[7:0] == IRU_OFF_EA) begin
			next_rdata = {16'h0000, ea};
		end else if (haddr_i[7:0] == IRU_OFF_STATUS) begin
			next_rdata = {30'h0, err_mode, busy};
		end
	end

	// Read data is registered in the address phase and stands through the data phase.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_o <= 32'h0000_0000;
		end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
			hrdata_o <= next_rdata;
		end
	end

	// Software base address register.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			base <= IRU_RST_BASE;
		end else if (wr_base) begin
			base <= hwdata_i[15:0];
		end
	end

	// Operand register: an immediate from software, or the byte that memory returns.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			oper <= IRU_RST_INDEX;
		end else if (wr_oper) begin
			oper <= hwdata_i[IW-1:0];
		end else if (state == IRU_ST_FETCH && mem_rsp_i.valid) begin
			oper <= mem_rsp_i.data;
		end
	end

	// Command latch; loads may use only the five sources of RULE_04, so a load from any other source is refused.
	// A refused load leaves both index registers and the flags as they were.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cur_op    <= IRU_OP_NONE;
			cur_mode  <= IRU_MODE_IMM;
			cur_sel_y <= 1'b0;
			err_mode  <= 1'b0;
		end else if (start) begin
			cur_op    <= iru_op_t'(hwdata_i[IRU_CMD_OP_LSB +: 4]);
			cur_mode  <= iru_mode_t'(hwdata_i[IRU_CMD_MODE_LSB +: 3]);
			cur_sel_y <= hwdata_i[IRU_CMD_REG_BIT];
			err_mode  <= (hwdata_i[IRU_CMD_OP_LSB +: 4] == 4'(IRU_OP_LOAD))
				&& !iru_load_src_ok(hwdata_i[IRU_CMD_MODE_LSB +: 3]); // [RULE_04]
		end
	end

	// Sequencer: address add, optional memory fetch, then register write-back.
	// A fetch waits for memory with no limit, so a silent memory keeps the unit busy.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= IRU_ST_IDLE;
		end else begin
			case (state)
				IRU_ST_IDLE: begin
					if (start) begin
						state <= IRU_ST_ADDR;
					end
				end
				IRU_ST_ADDR: begin
					if (err_mode) begin
						state <= IRU_ST_IDLE;
					end else if ((cur_op == IRU_OP_LOAD) && iru_needs_fetch(cur_mode)) begin
						state <= IRU_ST_FETCH; // [RULE_04]
					end else begin
						state <= IRU_ST_DONE;
					end
				end
				IRU_ST_FETCH: begin
					if (mem_rsp_i.valid) begin
						state <= IRU_ST_DONE;
					end
				end
				IRU_ST_DONE: begin
					state <= IRU_ST_IDLE;
				end
				default: begin
					state <= IRU_ST_IDLE;
				end
			endcase
		end
	end

	// The load of X is offset by Y; the other index offsets loads of Y.
	assign adder_index = iru_indexed(cur_mode) ? (cur_sel_y ? x_index : y_index) : '0;
	assign zp_mode     = (cur_mode == IRU_MODE_ZP) || (cur_mode == IRU_MODE_ZPIX);

	iru_adder #(
		.AW(16),
		.IW(IW)
	) u_adder (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n),
		.base_i      (base),
		.index_i     (adder_index),
		.zero_page_i (zp_mode),
		.ea_o        (ea)
	);

	// Memory request stands through the fetch state until the answer arrives.
	// The address comes straight from the adder flop, so it never glitches.
	assign mem_req_o.valid = (state == IRU_ST_FETCH);
	assign mem_req_o.addr  = ea;

	// Eight-bit result of the operation; carry out is discarded on both wraps.
	always_comb begin
		next_index = '0;
		wr_index   = 1'b0;
		if (state == IRU_ST_DONE) begin
			case (cur_op)
				IRU_OP_LOAD: begin
					next_index = oper; // [RULE_01]
					wr_index   = 1'b1;
				end
				IRU_OP_INC: begin
					next_index = (cur_sel_y ? y_index : x_index) + IW'(1); // [RULE_11] [RULE_07]
					wr_index   = 1'b1;
				end
				IRU_OP_DEC: begin
					next_index = (cur_sel_y ? y_index : x_index) - IW'(1); // [RULE_08] [RULE_07]
					wr_index   = 1'b1;
				end
				default: begin
					next_index = '0;
					wr_index   = 1'b0;
				end
			endcase
		end
	end

	// Zero and sign of the new value, shared by every operation that writes an index.
	assign next_zero = (next_index == '0);
	assign next_sign = next_index[IRU_SIGN_BIT];

	// Each index register is eight bits; only the selected one is written.
	// A step on Y updates the zero and sign flags the same way as a step on X.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			x_index <= IRU_RST_INDEX; // [RULE_05]
			y_index <= IRU_RST_INDEX;
		end else if (wr_index) begin
			if (cur_sel_y) begin
				y_index <= next_index;
			end else begin
				x_index <= next_index; // [RULE_01]
			end
		end
	end

	// Flags: Z and N follow the new index; C and V change only on a software write of the flags register.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			flags <= IRU_RST_FLAGS;
		end else if (wr_flags) begin
			flags <= hwdata_i[7:0];
		end else if (wr_index) begin
			flags[IRU_FLAG_Z] <= next_zero; // [RULE_02] [RULE_09] [RULE_10]
			flags[IRU_FLAG_N] <= next_sign; // [RULE_03] [RULE_08] [RULE_10]
		end
	end
endmodule
`default_nettype wire

// *** iru_top_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module iru_top_chk
	import iru_pkg::*;
(
	// Clock and reset.
	input wire logic         clk_i,
	input wire logic         reset_n_i,
	// Register bus.
	input wire logic         hsel_i,
	input wire logic [31:0]  haddr_i,
	input wire logic [1:0]   htrans_i,
	input wire logic         hwrite_i,
	input wire logic [31:0]  hwdata_i,
	input wire logic         hready_i,
	// Memory bus.
	input wire iru_mem_req_t mem_req_o,
	input wire iru_mem_rsp_t mem_rsp_i
);
	logic        wr_q;
	logic [7:0]  wa_q;
	logic [15:0] base_q;
	logic        cmd_w;
	logic [3:0]  op_w;
	logic [2:0]  md_w;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Follow each write into its data phase, where the value really lands.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			base_q <= 16'h0000;
		end else begin
			wr_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
			wa_q <= haddr_i[7:0];
			if (wr_q && wa_q == IRU_OFF_BASE) begin
				base_q <= hwdata_i[15:0];
			end
		end
	end
	// A command is seen in the data phase of its write.
	assign cmd_w = wr_q && wa_q == IRU_OFF_CMD;
	assign op_w = hwdata_i[3:0];
	assign md_w = hwdata_i[6:4];
	a_imm_no_fetch: assert property (
		cmd_w && op_w == IRU_OP_LOAD && md_w == IRU_MODE_IMM |=> !mem_req_o.valid [*3])
		else $error("Immediate load went to memory.");
	a_abs_fetch_addr: assert property (
		cmd_w && op_w == IRU_OP_LOAD && md_w == IRU_MODE_ABS
		|-> ##[1:4] (mem_req_o.valid && mem_req_o.addr == base_q))
		else $error("Absolute fetch address wrong.");
	a_zp_fetch_addr: assert property (
		cmd_w && op_w == IRU_OP_LOAD && md_w == IRU_MODE_ZP
		|-> ##[1:4] (mem_req_o.valid && mem_req_o.addr == {8'h00, base_q[7:0]}))
		else $error("Zero page fetch address wrong.");
	a_zpix_page_zero: assert property (
		cmd_w && op_w == IRU_OP_LOAD && md_w == IRU_MODE_ZPIX
		|-> ##[1:4] (mem_req_o.valid && mem_req_o.addr[15:8] == 8'h00))
		else $error("Indexed zero page fetch left page zero.");
	a_bad_mode_quiet: assert property (
		cmd_w && op_w == IRU_OP_LOAD && md_w == IRU_MODE_INDIR |=> !mem_req_o.valid [*4])
		else $error("Unsupported load source went to memory.");
	a_step_no_fetch: assert property (
		cmd_w && (op_w == IRU_OP_INC || op_w == IRU_OP_DEC) |=> !mem_req_o.valid [*4])
		else $error("Step operation went to memory.");
	a_req_held: assert property (
		mem_req_o.valid && !mem_rsp_i.valid |=> mem_req_o.valid && $stable(mem_req_o.addr))
		else $error("Fetch dropped or moved before the answer.");
	a_req_ends: assert property (
		mem_req_o.valid && mem_rsp_i.valid |=> !mem_req_o.valid)
		else $error("Fetch still raised after the answer.");
	c_abs_load: cover property (cmd_w && op_w == IRU_OP_LOAD && md_w == IRU_MODE_ABS);
	c_dec: cover property (cmd_w && op_w == IRU_OP_DEC);
	c_answer: cover property (mem_req_o.valid && mem_rsp_i.valid);
endmodule
bind iru_top iru_top_chk u_iru_top_chk (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
	.hready_i(hready_i), .mem_req_o(mem_req_o), .mem_rsp_i(mem_rsp_i)
);
`default_nettype wire

// *** iru_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module iru_mem_model
	import iru_pkg::*;
(
	// Clock, reset and answer delay.
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [3:0]   delay_i,
	// Memory bus.
	input  wire iru_mem_req_t req_i,
	output var iru_mem_rsp_t  rsp_o
);
	logic [3:0] cnt;
	logic       served;
	// One answer per request after delay_i cycles; the data lines toggle
	// between answers, so a stale byte is never taken for a fresh one.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 4'h0;
			served <= 1'b0;
			rsp_o <= '0;
		end else begin
			rsp_o.valid <= 1'b0;
			rsp_o.data <= ~rsp_o.data;
			if (!req_i.valid) begin
				cnt <= 4'h0;
				served <= 1'b0;
			end else if (!served && cnt == delay_i) begin
				rsp_o.valid <= 1'b1;
				rsp_o.data <= req_i.addr[7:0] ^ req_i.addr[15:8];
				served <= 1'b1;
			end else if (!served) begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// *** iru_top_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module iru_top_tb_top import iru_pkg::*; ;
	logic         clk_i, reset_n_i, hsel, hwrite, hready, hresp;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic [3:0]   dly;
	logic [31:0]  haddr, hwdata, hrdata, q;
	iru_mem_req_t mem_req;
	iru_mem_rsp_t mem_rsp;
	int           err_total, total_checks, cyc, i;
	logic [7:0]   v;
	logic [2:0]   md_t [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h2};
	logic [15:0]  bs_t [5] = '{16'h12fe, 16'h12fe, 16'h12fe, 16'h12fe, 16'h3400};
	logic [15:0]  ea_t [5] = '{16'h12fe, 16'h00fe, 16'h1301, 16'h0001, 16'h0000};
	iru_top u_iru_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .mem_req_o(mem_req), .mem_rsp_i(mem_rsp));
	iru_mem_model u_iru_mem_model (.clk_i(clk_i), .rst_n_i(reset_n_i), .delay_i(dly),
		.req_i(mem_req), .rsp_o(mem_rsp));
	// Free-running clock.
	always #5 clk_i = ~clk_i;
	// One single transfer; the address phase is held until hready is seen.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge clk_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// Busy never clearing shows up as a mismatch on the last poll.
	task automatic idle();
		for (int n = 0; n < 40; n++) begin
			bus(1'b0, IRU_OFF_STATUS, 32'h0);
			if (q[0] === 1'b0) return;
		end
		chk(q, 32'h0);
	endtask
	task automatic cmd(input logic [3:0] op, input logic [2:0] m, input logic y);
		bus(1'b1, IRU_OFF_CMD, {23'h0, y, 1'b0, m, op});
		idle();
	endtask
	// Expected flags: carry and overflow kept, sign and zero from the value.
	function automatic logic [31:0] nz(input logic [7:0] x);
		return {24'h0, x[7], 1'b1, 4'h0, x == 8'h00, 1'b1};
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Hang guard.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			report_and_stop();
		end
	end
	// Main sequence.
	initial begin
		{clk_i, reset_n_i, hsel, hwrite, htrans, haddr, hwdata, dly} = '0;
		hsize = 3'b010;
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rc(IRU_OFF_X, 32'h0);
		rc(IRU_OFF_FLAGS, 32'h0);
		bus(1'b1, IRU_OFF_FLAGS, 32'h41);
		bus(1'b1, IRU_OFF_OPER, 32'h80);
		cmd(IRU_OP_LOAD, IRU_MODE_IMM, 1'b0);
		rc(IRU_OFF_X, 32'h80);
		rc(IRU_OFF_FLAGS, nz(8'h80));
		rc(IRU_OFF_Y, 32'h0);
		bus(1'b1, IRU_OFF_OPER, 32'h0);
		cmd(IRU_OP_LOAD, IRU_MODE_IMM, 1'b0);
		rc(IRU_OFF_FLAGS, nz(8'h00));
		bus(1'b1, IRU_OFF_OPER, 32'h3);
		cmd(IRU_OP_LOAD, IRU_MODE_IMM, 1'b1);
		rc(IRU_OFF_Y, 32'h3);
		$display("test immediate load done");
		for (i = 0; i < 5; i++) begin
			dly <= 4'(i * 2);
			bus(1'b1, IRU_OFF_BASE, {16'h0, bs_t[i]});
			cmd(IRU_OP_LOAD, md_t[i], 1'b0);
			v = ea_t[i][7:0] ^ ea_t[i][15:8];
			rc(IRU_OFF_EA, {16'h0, ea_t[i]});
			rc(IRU_OFF_X, {24'h0, v});
			rc(IRU_OFF_FLAGS, nz(v));
		end
		$display("test memory load done");
		bus(1'b1, IRU_OFF_OPER, 32'h2);
		cmd(IRU_OP_LOAD, IRU_MODE_IMM, 1'b0);
		for (v = 8'h02; v != 8'hff; v--) begin
			cmd(IRU_OP_DEC, IRU_MODE_IMM, 1'b0);
			rc(IRU_OFF_X, {24'h0, v - 8'h01});
			rc(IRU_OFF_FLAGS, nz(v - 8'h01));
		end
		cmd(IRU_OP_INC, IRU_MODE_IMM, 1'b0);
		rc(IRU_OFF_X, 32'h0);
		cmd(IRU_OP_INC, IRU_MODE_IMM, 1'b1);
		rc(IRU_OFF_Y, 32'h4);
		cmd(IRU_OP_DEC, IRU_MODE_IMM, 1'b1);
		rc(IRU_OFF_Y, 32'h3);
		$display("test step done");
		cmd(IRU_OP_EA, IRU_MODE_INDIR, 1'b0);
		rc(IRU_OFF_EA, 32'h3403);
		rc(IRU_OFF_STATUS, 32'h0);
		bus(1'b1, IRU_OFF_X, 32'h55);
		rc(IRU_OFF_X, 32'h0);
		rc(8'h40, 32'h0);
		cmd(IRU_OP_LOAD, IRU_MODE_INDIR, 1'b0);
		rc(IRU_OFF_STATUS, 32'h2);
		rc(IRU_OFF_X, 32'h0);
		$display("test refusals done");
		report_and_stop();
	end
endmodule
`default_nettype wire
